// ==== inc/rce_defs.svh ====
`ifndef RCE_DEFS_SVH
`define RCE_DEFS_SVH

`define RCE_CLK_NS 100
`define RCE_CHIP_NS 100000
`define RCE_CHIP_CYC (`RCE_CHIP_NS / `RCE_CLK_NS)
`define RCE_SETTLE_CYC 8
`define RCE_SYNC_CHIPS 12
`define RCE_WORDS 3
`define RCE_ADDR_N 10
`define RCE_DATA_N 8
`define RCE_TRITS (`RCE_ADDR_N + `RCE_DATA_N)
`define RCE_LAG_MS 150
`define RCE_LAG_CYC (`RCE_LAG_MS * 1000000 / `RCE_CLK_NS)
`define RCE_FIFO_DEPTH 8

`endif

// ==== inc/rce_pkg.sv ====
package rce_pkg;

    typedef enum logic [1:0] {
        RCE_T_LOW = 2'h0,
        RCE_T_FLOAT = 2'h1,
        RCE_T_HIGH = 2'h3
    } rce_trit_t;

    typedef struct packed {
        logic last;
        rce_trit_t trit;
    } rce_sym_t;

    typedef enum logic [2:0] {
        RCE_ST_IDLE = 3'h0,
        RCE_ST_PROBE_HI = 3'h1,
        RCE_ST_PROBE_LO = 3'h2,
        RCE_ST_FEED = 3'h3,
        RCE_ST_DRAIN = 3'h4
    } rce_state_t;

endpackage : rce_pkg

// ==== design/rce_fifo.sv ====
module rce_fifo #(
    parameter int WIDTH = 3,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
    logic full, empty, we, re;

    // Pointers carry one extra bit so that full and empty differ.
    assign empty = (wr_ff == rd_ff);
    assign full = (wr_ff[AW-1:0] == rd_ff[AW-1:0]) && (wr_ff[AW] != rd_ff[AW]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ff[AW-1:0]];
    assign we = in_valid && !full;
    assign re = out_ready && !empty;

    always_comb begin
        nxt_wr = wr_ff + (AW+1)'(we);
        nxt_rd = rd_ff + (AW+1)'(re);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ff <= '0;
            rd_ff <= '0;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
        end
    end

    always_ff @(posedge clk) begin
        if (we) begin
            mem[wr_ff[AW-1:0]] <= in_data;
        end
    end

    AST_FIFO_NO_OVERFLOW: assert property (@(posedge clk) disable iff (!rst_n)
        full |=> (wr_ff == $past(wr_ff)))
        else $error("FIFO pointer moved while full.");

endmodule : rce_fifo

// ==== design/rce_encoder.sv ====
`include "rce_defs.svh"

module rce_encoder import rce_pkg::*; #(
    parameter int CHIP_CYC = `RCE_CHIP_CYC,
    parameter int SETTLE_CYC = `RCE_SETTLE_CYC,
    parameter int SYNC_CHIPS = `RCE_SYNC_CHIPS,
    parameter int LAG_CYC = `RCE_LAG_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic tx_go_line,
    input wire logic [`RCE_ADDR_N-1:0] addr_trit_inputs,
    input wire logic [`RCE_DATA_N-1:0] payload_inputs,
    output logic probe_pull_up_ff,
    output logic serial_out_ff,
    output logic busy_ff
);
    localparam int NT = `RCE_TRITS;

    function automatic rce_trit_t rce_decode(input logic hi, input logic lo);
        if (hi && lo) begin
            return RCE_T_HIGH;
        end else if (!hi && !lo) begin
            return RCE_T_LOW;
        end
        return RCE_T_FLOAT;
    endfunction : rce_decode

    logic rst_meta_ff, rst_n_ff;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // Pins and go share one three-stage chain; a level is accepted
    // only when stages two and three agree.
    logic [NT:0] s1_ff, s2_ff, s3_ff, pin_ff, nxt_pin;
    logic go_ff;
    logic [NT-1:0] pins;
    assign go_ff = pin_ff[NT];
    assign pins = pin_ff[NT-1:0];

    always_comb begin
        nxt_pin = (s2_ff & ~(s2_ff ^ s3_ff)) | (pin_ff & (s2_ff ^ s3_ff));
    end

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            pin_ff <= '0;
        end else begin
            s1_ff <= {tx_go_line, payload_inputs, addr_trit_inputs};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            pin_ff <= nxt_pin;
        end
    end

    rce_state_t state_ff, nxt_state;
    logic [7:0] cnt_ff, nxt_cnt;
    logic [4:0] idx_ff, nxt_idx;
    logic [1:0] word_ff, nxt_word;
    logic [NT-1:0] hi_ff, lo_ff, nxt_hi, nxt_lo;
    logic nxt_probe, nxt_busy;
    logic push, push_rdy, pop, pop_valid, ser_busy_ff;
    rce_sym_t push_sym, pop_sym;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_idx = idx_ff;
        nxt_word = word_ff;
        nxt_hi = hi_ff;
        nxt_lo = lo_ff;
        nxt_probe = probe_pull_up_ff;
        push = 1'b0;
        push_sym.trit = rce_decode(hi_ff[idx_ff], lo_ff[idx_ff]);
        push_sym.last = (idx_ff == 5'(NT - 1));
        unique case (state_ff)
            RCE_ST_IDLE: begin
                nxt_probe = 1'b1;
                nxt_cnt = '0;
                if (go_ff) begin
                    nxt_state = RCE_ST_PROBE_HI;
                end
            end
            // Each pin is read once with a weak pull up and once with a
            // weak pull down; a pin that follows the pull is floating.
            RCE_ST_PROBE_HI: begin
                nxt_cnt = cnt_ff + 8'h01;
                if (cnt_ff == 8'(SETTLE_CYC - 1)) begin
                    nxt_hi = pins;
                    nxt_probe = 1'b0;
                    nxt_cnt = '0;
                    nxt_state = RCE_ST_PROBE_LO;
                end
            end
            RCE_ST_PROBE_LO: begin
                nxt_cnt = cnt_ff + 8'h01;
                if (cnt_ff == 8'(SETTLE_CYC - 1)) begin
                    nxt_lo = pins;
                    nxt_probe = 1'b1;
                    nxt_idx = '0;
                    nxt_word = '0;
                    nxt_state = RCE_ST_FEED;
                end
            end
            RCE_ST_FEED: begin
                push = 1'b1;
                if (push_rdy) begin
                    if (idx_ff == 5'(NT - 1)) begin
                        nxt_idx = '0;
                        if (word_ff == 2'(`RCE_WORDS - 1)) begin
                            nxt_state = RCE_ST_DRAIN;
                        end else begin
                            nxt_word = word_ff + 2'h1;
                        end
                    end else begin
                        nxt_idx = idx_ff + 5'h01;
                    end
                end
            end
            RCE_ST_DRAIN: begin
                nxt_cnt = '0;
                if (!pop_valid && !ser_busy_ff) begin
                    // Once a cycle has left IDLE, go is checked only here, so a drop mid-cycle still
                    // lets all three words go out.
                    if (go_ff) begin
                        nxt_state = RCE_ST_PROBE_HI;
                    end else begin
                        nxt_state = RCE_ST_IDLE;
                    end
                end
            end
            default: begin
                nxt_state = RCE_ST_IDLE;
            end
        endcase
        nxt_busy = (nxt_state != RCE_ST_IDLE);
    end

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            state_ff <= RCE_ST_IDLE;
            cnt_ff <= '0;
            idx_ff <= '0;
            word_ff <= '0;
            hi_ff <= '0;
            lo_ff <= '0;
            probe_pull_up_ff <= 1'b1;
            busy_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            idx_ff <= nxt_idx;
            word_ff <= nxt_word;
            hi_ff <= nxt_hi;
            lo_ff <= nxt_lo;
            probe_pull_up_ff <= nxt_probe;
            busy_ff <= nxt_busy;
        end
    end

    rce_fifo #(
        .WIDTH($bits(rce_sym_t)),
        .DEPTH(`RCE_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n_ff),
        .in_valid(push),
        .in_data(push_sym),
        .in_ready(push_rdy),
        .out_valid(pop_valid),
        .out_data(pop_sym),
        .out_ready(!ser_busy_ff)
    );

    // Serializer: bit = three chips, high for one chip (0) or two (1).
    // Trit low = 00, high = 11, floating = 10; a low gap ends each word.
    rce_sym_t sym_ff, nxt_sym;
    logic bit_ff, gap_ff, nxt_bit, nxt_gap, nxt_sbusy, nxt_out;
    logic [1:0] chip_ff, nxt_chip;
    logic [15:0] tmr_ff, nxt_tmr;
    logic [7:0] gcnt_ff, nxt_gcnt;
    assign pop = pop_valid && !ser_busy_ff;

    always_comb begin
        nxt_sym = sym_ff;
        nxt_bit = bit_ff;
        nxt_gap = gap_ff;
        nxt_sbusy = ser_busy_ff;
        nxt_chip = chip_ff;
        nxt_tmr = tmr_ff;
        nxt_gcnt = gcnt_ff;
        nxt_out = ser_busy_ff && !gap_ff && ((chip_ff == 2'h0) ||
            ((chip_ff == 2'h1) && sym_ff.trit[bit_ff]));
        if (pop) begin
            nxt_sym = pop_sym;
            nxt_sbusy = 1'b1;
            nxt_bit = 1'b0;
            nxt_chip = '0;
            nxt_tmr = '0;
            nxt_gap = 1'b0;
        end else if (ser_busy_ff) begin
            nxt_tmr = tmr_ff + 16'h0001;
            if (tmr_ff == 16'(CHIP_CYC - 1)) begin
                nxt_tmr = '0;
                if (gap_ff) begin
                    nxt_gcnt = gcnt_ff + 8'h01;
                    if (gcnt_ff == 8'(SYNC_CHIPS - 1)) begin
                        nxt_sbusy = 1'b0;
                        nxt_gap = 1'b0;
                    end
                end else if (chip_ff == 2'h2) begin
                    nxt_chip = '0;
                    if (bit_ff) begin
                        nxt_gap = sym_ff.last;
                        nxt_gcnt = '0;
                        nxt_sbusy = sym_ff.last;
                    end else begin
                        nxt_bit = 1'b1;
                    end
                end else begin
                    nxt_chip = chip_ff + 2'h1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            sym_ff <= '0;
            bit_ff <= 1'b0;
            gap_ff <= 1'b0;
            ser_busy_ff <= 1'b0;
            chip_ff <= '0;
            tmr_ff <= '0;
            gcnt_ff <= '0;
            serial_out_ff <= 1'b0;
        end else begin
            sym_ff <= nxt_sym;
            bit_ff <= nxt_bit;
            gap_ff <= nxt_gap;
            ser_busy_ff <= nxt_sbusy;
            chip_ff <= nxt_chip;
            tmr_ff <= nxt_tmr;
            gcnt_ff <= nxt_gcnt;
            serial_out_ff <= nxt_out;
        end
    end

    // Helper: cycles since the current sampling began.
    logic [31:0] lag_ff;
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            lag_ff <= '0;
        end else if (state_ff == RCE_ST_IDLE || nxt_state == RCE_ST_PROBE_HI &&
                     state_ff != RCE_ST_PROBE_HI) begin
            lag_ff <= '0;
        end else begin
            lag_ff <= lag_ff + 32'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_ff);

    AST_START: assert property (
        (state_ff == RCE_ST_IDLE && go_ff) |=> state_ff == RCE_ST_PROBE_HI)
        else $error("Cycle did not start on go.");
    AST_THREE_WORDS: assert property (
        (state_ff == RCE_ST_FEED && push_rdy && push_sym.last &&
         word_ff == 2'h2) |=> state_ff == RCE_ST_DRAIN)
        else $error("Cycle did not end after the third word.");
    AST_REPEAT: assert property (
        (state_ff == RCE_ST_DRAIN && !pop_valid && !ser_busy_ff && go_ff)
        |=> state_ff == RCE_ST_PROBE_HI ##SETTLE_CYC
        state_ff == RCE_ST_PROBE_LO)
        else $error("Next cycle did not resample.");
    AST_STOP: assert property (
        (state_ff == RCE_ST_DRAIN && !pop_valid && !ser_busy_ff && !go_ff)
        |=> state_ff == RCE_ST_IDLE ##1 !ser_busy_ff)
        else $error("Encoder did not stop after the last cycle.");
    AST_FINISH: assert property (
        (state_ff == RCE_ST_FEED && !go_ff) |=> state_ff != RCE_ST_IDLE)
        else $error("Cycle cut short by go falling.");
    AST_ORDER: assert property (
        (push && push_rdy && !push_sym.last) |=>
        (idx_ff == $past(idx_ff) + 5'h01))
        else $error("Trit order broken.");
    AST_TRIT: assert property (
        (pop && pop_sym.trit == RCE_T_FLOAT) |=> ##1
        sym_ff.trit == rce_decode(1'b1, 1'b0))
        else $error("Floating trit corrupted.");
    AST_SYNC: assert property (
        $changed(go_ff) |-> $past(s2_ff[NT]) == $past(s3_ff[NT]))
        else $error("Go accepted before stages agreed.");
    AST_QUIET: assert property (
        (!ser_busy_ff && !pop) |=> !serial_out_ff)
        else $error("Serial output active while idle.");
    AST_LAG: assert property (
        lag_ff < 32'(LAG_CYC))
        else $error("Cycle exceeded the refresh lag.");

    COV_START: cover property ($rose(state_ff == RCE_ST_PROBE_HI));
    COV_REPEAT: cover property (
        state_ff == RCE_ST_DRAIN ##1 state_ff == RCE_ST_PROBE_HI);
    COV_STOP: cover property (
        state_ff == RCE_ST_DRAIN ##1 state_ff == RCE_ST_IDLE);
    COV_FLOAT: cover property (pop && pop_sym.trit == RCE_T_FLOAT);

endmodule : rce_encoder

// ==== dv/rce_rx_model.sv ====
module rce_rx_model #(
    parameter int CHIP = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic serial_in,
    input wire logic [19:0] local_addr,
    output int words_seen,
    output logic [35:0] word_q,
    output logic addr_ok,
    output logic [7:0] data_q
);
    timeunit 1ns;
    timeprecision 1ns;
    int hi_n;
    int lo_n;
    int nb;
    logic prev;
    logic [35:0] sh;

    // A low run of four chips closes a word; a word of fewer than 36 bits is dropped.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_n <= 0;
            lo_n <= 0;
            nb <= 0;
            prev <= 1'b0;
            sh <= '0;
            words_seen <= 0;
            word_q <= '0;
            addr_ok <= 1'b0;
            data_q <= '0;
        end else begin
            prev <= serial_in;
            if (serial_in) begin
                hi_n <= hi_n + 1;
                lo_n <= 0;
            end else begin
                lo_n <= lo_n + 1;
                hi_n <= 0;
                if (prev && nb < 36) begin
                    sh[nb] <= hi_n > (CHIP * 3) / 2;
                    nb <= nb + 1;
                end
                if (lo_n == 4 * CHIP) begin
                    nb <= 0;
                    if (nb == 36) begin
                        words_seen <= words_seen + 1;
                        word_q <= sh;
                        addr_ok <= sh[19:0] == local_addr;
                        if (sh[19:0] == local_addr) begin
                            for (int j = 0; j < 8; j++)
                                data_q[j] <= sh[20+2*j] & sh[21+2*j];
                        end
                    end
                end
            end
        end
    end
endmodule : rce_rx_model

// ==== dv/tb_top.sv ====
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic tx_go_line = 1'b0;
    logic [9:0] a_en = 10'h000;
    logic [9:0] a_val = 10'h000;
    logic [7:0] d_en = 8'h00;
    logic [7:0] d_val = 8'h00;
    logic [19:0] rx_addr = 20'h00000;
    logic [9:0] addr_pins;
    logic [7:0] data_pins;
    logic probe;
    logic ser;
    logic busy;
    int words_seen;
    logic [35:0] word_q;
    logic addr_ok;
    logic [7:0] data_q;
    int errors = 0;
    int samples_checked = 0;
    int cyc = 0;

    always #50 clk = ~clk;
    always @(posedge clk) cyc++;

    // Undriven pins follow the weak pull that the encoder applies.
    assign addr_pins = (a_en & a_val) | (~a_en & {10{probe}});
    assign data_pins = (d_en & d_val) | (~d_en & {8{probe}});

    rce_encoder #(.CHIP_CYC(4), .SETTLE_CYC(8), .SYNC_CHIPS(3),
        .LAG_CYC(6000)) i_dut (
        .clk(clk),
        .resetn(resetn),
        .tx_go_line(tx_go_line),
        .addr_trit_inputs(addr_pins),
        .payload_inputs(data_pins),
        .probe_pull_up_ff(probe),
        .serial_out_ff(ser),
        .busy_ff(busy)
    );

    rce_rx_model #(.CHIP(4)) i_rx (
        .clk(clk),
        .rst_n(resetn),
        .serial_in(ser),
        .local_addr(rx_addr),
        .words_seen(words_seen),
        .word_q(word_q),
        .addr_ok(addr_ok),
        .data_q(data_q)
    );

    task automatic close_out();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Low sends 00, high 11 and floating 1 then 0; index 0 goes first.
    function automatic logic [35:0] exp_word();
        logic [35:0] w;
        logic [17:0] en;
        logic [17:0] v;
        en = {d_en, a_en};
        v = {d_val, a_val};
        for (int i = 0; i < 18; i++)
            w[2*i +: 2] = en[i] ? {2{v[i]}} : 2'h1;
        return w;
    endfunction : exp_word

    task automatic next_word(output logic [35:0] w);
        int n0;
        n0 = words_seen;
        w = 'x;
        repeat (3000) begin
            @(negedge clk);
            if (words_seen != n0) begin
                w = word_q;
                break;
            end
        end
    endtask : next_word

    task automatic expect_quiet();
        int n0;
        n0 = words_seen;
        repeat (3000) @(negedge clk);
        check(36'(words_seen - n0), 36'h0);
        check({35'h0, busy}, 36'h0);
    endtask : expect_quiet

    task automatic expect_words(input int n, input logic [35:0] exp);
        logic [35:0] w;
        for (int k = 0; k < n; k++) begin
            next_word(w);
            check(w, exp);
        end
    endtask : expect_words

    // Go drops while the pins are still being probed; the cycle completes.
    task automatic t_burst();
        logic [35:0] w0;
        a_en = 10'h2B5;
        a_val = 10'h0F0;
        d_en = 8'hA7;
        d_val = 8'h3C;
        w0 = exp_word();
        rx_addr = w0[19:0];
        tx_go_line = 1'b1;
        repeat (10) @(negedge clk);
        tx_go_line = 1'b0;
        expect_words(3, exp_word());
        check({27'h0, addr_ok, data_q}, 36'h124);
        expect_quiet();
    endtask : t_burst

    // Data changed mid-cycle shows only from the next cycle on.
    task automatic t_refresh();
        logic [35:0] old_w;
        int t0;
        old_w = exp_word();
        tx_go_line = 1'b1;
        expect_words(1, old_w);
        d_en = 8'hFF;
        d_val = 8'hC3;
        t0 = cyc;
        expect_words(2, old_w);
        expect_words(1, exp_word());
        check(36'(cyc - t0 > 6000), 36'h0);
        tx_go_line = 1'b0;
        expect_words(2, exp_word());
        check(36'(data_q), 36'hC3);
        expect_quiet();
    endtask : t_refresh

    // Go tied high through a reset: sending starts once reset lets go.
    task automatic t_powerup();
        d_en = 8'h0F;
        d_val = 8'h05;
        tx_go_line = 1'b1;
        resetn = 1'b0;
        repeat (3) @(negedge clk);
        check({33'h0, probe, ser, busy}, 36'h4);
        resetn = 1'b1;
        expect_words(1, exp_word());
        tx_go_line = 1'b0;
        expect_words(2, exp_word());
        check(36'(data_q), 36'h05);
        expect_quiet();
    endtask : t_powerup

    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, cyc, 60000);
        close_out();
    end

    initial begin
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        repeat (10) @(negedge clk);
        t_burst();
        t_refresh();
        t_powerup();
        close_out();
    end
endmodule : tb_top
